// ===== core/ldgr_consts.svh
`ifndef LDGR_CONSTS_SVH
`define LDGR_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LDGR_OFS_GROUP_A_DUTY  7'h40
`define LDGR_OFS_GROUP_B_DUTY  7'h41
`define LDGR_OFS_CHANNEL1      7'h42
`define LDGR_OFS_CHANNEL2      7'h43

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define LDGR_DUTY_MSB          11
`define LDGR_ENABLE_BIT        12
`define LDGR_REG_RESET         13'h0000
`define LDGR_DUTY_OFF          12'h000
`define LDGR_DUTY_FULL         12'hFFF
`define LDGR_NUM_CHANNELS      12

`endif

// ===== core/ldgr_pkg.sv
package ldgr_pkg;

	// one dimming word: bit 12 enable, bits 11:0 duty
	typedef struct packed {
		logic        dim_ctl;
		logic [11:0] duty;
	} ldgr_dim_t;

	// register access strobe and its data
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [6:0]  addr;
		logic [12:0] wdata;
	} ldgr_req_t;

endpackage

// ===== core/ldgr_regs.sv
// Operation
// RULE1: group A write copies duty to members
// RULE2: group B write copies duty to members
// RULE3: twelve-bit duty, zero off, ones on
// RULE4: group bit 12 enable applied to members
// RULE5: channel 1 duty, bit12 zero enables
// RULE6: channel 2 same layout and polarity
// RULE7: non-members untouched, latest group wins
`timescale 1ns/1ns
`include "ldgr_consts.svh"

module ldgr_regs
	import ldgr_pkg::*;
(
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_reset,
	input  wire ldgr_req_t            i_req,
	input  wire logic [11:0]          i_group_a_membership,
	input  wire logic [11:0]          i_group_b_membership,
	output logic      [12:0]          o_rdata,
	output logic                      o_rvalid,
	output ldgr_dim_t [11:0]          o_channel
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	ldgr_dim_t        group_a_duty_r;
	ldgr_dim_t        group_a_duty_nxt;
	ldgr_dim_t        group_b_duty_r;
	ldgr_dim_t        group_b_duty_nxt;
	ldgr_dim_t [11:0] chan_r;
	ldgr_dim_t [11:0] chan_nxt;
	logic      [12:0] rdata_r;
	logic      [12:0] rdata_nxt;
	logic             rvalid_r;
	logic             rvalid_nxt;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	logic wr_a;
	logic wr_b;
	logic wr_c1;
	logic wr_c2;

	assign wr_a  = i_req.wr && i_req.addr == `LDGR_OFS_GROUP_A_DUTY;
	assign wr_b  = i_req.wr && i_req.addr == `LDGR_OFS_GROUP_B_DUTY;
	assign wr_c1 = i_req.wr && i_req.addr == `LDGR_OFS_CHANNEL1;
	assign wr_c2 = i_req.wr && i_req.addr == `LDGR_OFS_CHANNEL2;

	// ----------------------------------------------------------------
	// next-value logic
	// ----------------------------------------------------------------
	always_comb begin
		group_a_duty_nxt = group_a_duty_r;
		group_b_duty_nxt = group_b_duty_r;
		chan_nxt         = chan_r;
		if (wr_a) begin
			group_a_duty_nxt = ldgr_dim_t'(i_req.wdata);
		end
		if (wr_b) begin
			group_b_duty_nxt = ldgr_dim_t'(i_req.wdata);
		end
		for (int i = 0; i < `LDGR_NUM_CHANNELS; i++) begin
			// only members change; one write per cycle, so latest wins
			if (wr_a && i_group_a_membership[i]) begin
				chan_nxt[i] = ldgr_dim_t'(i_req.wdata); // [RULE1] [RULE4] [RULE7]
			end
			if (wr_b && i_group_b_membership[i]) begin
				chan_nxt[i] = ldgr_dim_t'(i_req.wdata); // [RULE2] [RULE4] [RULE7]
			end
		end
		if (wr_c1) begin
			chan_nxt[0] = ldgr_dim_t'(i_req.wdata); // [RULE5] [RULE3]
		end
		if (wr_c2) begin
			chan_nxt[1] = ldgr_dim_t'(i_req.wdata); // [RULE6] [RULE3]
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		rvalid_nxt = i_req.rd;
		rdata_nxt  = 13'h0000;
		if (i_req.rd) begin
			unique case (i_req.addr)
				`LDGR_OFS_GROUP_A_DUTY: rdata_nxt = group_a_duty_r;
				`LDGR_OFS_GROUP_B_DUTY: rdata_nxt = group_b_duty_r;
				`LDGR_OFS_CHANNEL1:     rdata_nxt = chan_r[0];
				`LDGR_OFS_CHANNEL2:     rdata_nxt = chan_r[1];
				default:                rdata_nxt = 13'h0000;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rdata_r  <= 13'h0000;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// register update
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			group_a_duty_r <= `LDGR_REG_RESET;
			group_b_duty_r <= `LDGR_REG_RESET;
			chan_r         <= '0;
		end else begin
			group_a_duty_r <= group_a_duty_nxt;
			group_b_duty_r <= group_b_duty_nxt;
			chan_r         <= chan_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_channel = chan_r;
	assign o_rdata   = rdata_r;
	assign o_rvalid  = rvalid_r;

	// ----------------------------------------------------------------
	// per-channel checks
	// ----------------------------------------------------------------
	for (genvar g = 0; g < `LDGR_NUM_CHANNELS; g++) begin : g_chan_chk
		a_group_a_copy: assert property ( // [RULE1]
			@(posedge i_ref_clk) disable iff (i_reset)
			wr_a && i_group_a_membership[g] |=>
			o_channel[g] == $past(i_req.wdata))
			else $error("group A write not copied");

		a_group_b_copy: assert property ( // [RULE2]
			@(posedge i_ref_clk) disable iff (i_reset)
			wr_b && i_group_b_membership[g] |=>
			o_channel[g].duty == $past(i_req.wdata[11:0]))
			else $error("group B write not copied");

		a_group_enable: assert property ( // [RULE4]
			@(posedge i_ref_clk) disable iff (i_reset)
			wr_a && i_group_a_membership[g] |=>
			o_channel[g].dim_ctl == $past(i_req.wdata[12]))
			else $error("group enable not applied");

		a_group_b_enable: assert property ( // [RULE4]
			@(posedge i_ref_clk) disable iff (i_reset)
			wr_b && i_group_b_membership[g] |=>
			o_channel[g].dim_ctl == $past(i_req.wdata[12]))
			else $error("group B enable not applied");

		a_non_member: assert property ( // [RULE7]
			@(posedge i_ref_clk) disable iff (i_reset)
			wr_a && !i_group_a_membership[g] |=>
			$stable(o_channel[g]))
			else $error("non-member channel changed");

		a_group_b_keep: assert property ( // [RULE7]
			@(posedge i_ref_clk) disable iff (i_reset)
			wr_b && !i_group_b_membership[g] |=>
			$stable(o_channel[g]))
			else $error("group B non-member channel changed");
	end

	// ----------------------------------------------------------------
	// register checks
	// ----------------------------------------------------------------
	a_duty_width: assert property ( // [RULE3]
		@(posedge i_ref_clk) disable iff (i_reset)
		wr_c2 |=> o_channel[1].duty == $past(i_req.wdata[11:0]))
		else $error("duty field width wrong");

	a_chan1_write: assert property ( // [RULE5]
		@(posedge i_ref_clk) disable iff (i_reset)
		wr_c1 ##1
		(i_req.rd && i_req.addr == `LDGR_OFS_CHANNEL1) |=>
		o_rvalid && o_rdata == $past(i_req.wdata, 2))
		else $error("channel 1 readback wrong");

	a_chan_isolate: assert property ( // [RULE5]
		@(posedge i_ref_clk) disable iff (i_reset)
		wr_c1 |=> $stable(o_channel[1]))
		else $error("channel 1 write hit channel 2");

	a_chan1_enable: assert property ( // [RULE5]
		@(posedge i_ref_clk) disable iff (i_reset)
		wr_c1 |=> o_channel[0].dim_ctl == $past(i_req.wdata[12]))
		else $error("channel 1 enable not stored");

	a_chan2_write: assert property ( // [RULE6]
		@(posedge i_ref_clk) disable iff (i_reset)
		wr_c2 |=> o_channel[1] == $past(i_req.wdata))
		else $error("channel 2 write lost");

	a_chan2_read: assert property ( // [RULE6]
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.rd && i_req.addr == `LDGR_OFS_CHANNEL2 |=>
		o_rvalid && o_rdata == $past(o_channel[1]))
		else $error("channel 2 readback wrong");

	a_group_b_reg: assert property ( // [RULE2]
		@(posedge i_ref_clk) disable iff (i_reset)
		wr_b |=> group_b_duty_r == $past(i_req.wdata))
		else $error("group B register not stored");

	a_group_a_reg: assert property ( // [RULE1]
		@(posedge i_ref_clk) disable iff (i_reset)
		wr_a |=> group_a_duty_r == $past(i_req.wdata))
		else $error("group A register not stored");

	// ----------------------------------------------------------------
	// coverage
	// ----------------------------------------------------------------
	c_group_a: cover property (@(posedge i_ref_clk)
		wr_a && i_group_a_membership != 12'h000);
	c_group_b: cover property (@(posedge i_ref_clk)
		wr_b && (i_group_a_membership & i_group_b_membership) != 12'h000);
	c_chan_rd: cover property (@(posedge i_ref_clk)
		wr_c1 ##1 i_req.rd);
	c_group_full: cover property (@(posedge i_ref_clk)
		wr_b && i_req.wdata[11:0] == `LDGR_DUTY_FULL);
	c_chan_zero: cover property (@(posedge i_ref_clk)
		wr_c2 && i_req.wdata[11:0] == `LDGR_DUTY_OFF);

endmodule

// ===== tb/ldgr_host.sv
`timescale 1ns/1ns
module ldgr_host
	import ldgr_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic [12:0] i_rdata,
	input  wire logic        i_rvalid,
	output ldgr_req_t        o_req
);
	initial o_req = '0;
	// one access; request held for exactly one taking edge
	task automatic acc(input logic w, input logic [6:0] a,
		input logic [12:0] d, output logic [12:0] q);
		@(posedge i_ref_clk);
		o_req <= '{w, !w, a, d};
		@(posedge i_ref_clk);
		o_req <= '0;
		@(posedge i_ref_clk);
		q = i_rvalid ? i_rdata : 13'h1555;
	endtask
	// write, then read the same offset on the very next edge
	task automatic wr_rd(input logic [6:0] a, input logic [12:0] d,
		output logic [12:0] q);
		@(posedge i_ref_clk);
		o_req <= '{1'b1, 1'b0, a, d};
		@(posedge i_ref_clk);
		o_req <= '{1'b0, 1'b1, a, 13'h0000};
		@(posedge i_ref_clk);
		o_req <= '0;
		@(posedge i_ref_clk);
		q = i_rvalid ? i_rdata : 13'h1555;
	endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	import ldgr_pkg::*;
	logic             i_ref_clk = 1'b0;
	logic             i_reset   = 1'b1;
	logic [11:0]      mem_a     = 12'h000;
	logic [11:0]      mem_b     = 12'h000;
	ldgr_req_t        req;
	logic [12:0]      rdata;
	logic             rvalid;
	ldgr_dim_t [11:0] ch;
	logic [12:0]      q;
	int               error_cnt = 0;
	int               compares  = 0;
	initial forever #5 i_ref_clk = ~i_ref_clk;
	ldgr_regs dut_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
		.i_req(req), .i_group_a_membership(mem_a),
		.i_group_b_membership(mem_b), .o_rdata(rdata),
		.o_rvalid(rvalid), .o_channel(ch));
	ldgr_host host_u (.i_ref_clk(i_ref_clk), .i_rdata(rdata),
		.i_rvalid(rvalid), .o_req(req));
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [12:0] e);
		host_u.acc(1'b0, a, 13'h0000, q);
		chk(q, e);
	endtask
	task automatic sc_reset;
		for (int i = 0; i < 4; i++) begin
			rd_chk(7'(7'h40 + i), 13'h0000);
		end
		for (int i = 0; i < 12; i++) begin
			chk(ch[i], 13'h0000);
		end
		rd_chk(7'h44, 13'h0000);
	endtask
	// members in both groups and in neither
	task automatic sc_groups;
		mem_a <= 12'h490;
		mem_b <= 12'h520;
		host_u.acc(1'b1, 7'h40, 13'h10AA, q);
		for (int i = 0; i < 12; i++) begin
			chk(ch[i], mem_a[i] ? 13'h10AA : 13'h0000);
		end
		host_u.acc(1'b1, 7'h41, 13'h0FFF, q);
		for (int i = 0; i < 12; i++) begin
			chk(ch[i], mem_b[i] ? 13'h0FFF :
				(mem_a[i] ? 13'h10AA : 13'h0000));
		end
		rd_chk(7'h40, 13'h10AA);
		rd_chk(7'h41, 13'h0FFF);
	endtask
	task automatic sc_channels;
		host_u.wr_rd(7'h42, 13'h1001, q);
		chk(q, 13'h1001);
		host_u.acc(1'b1, 7'h43, 13'h0000, q);
		chk(ch[0], 13'h1001);
		chk(ch[1], 13'h0000);
		chk(ch[10], 13'h0FFF);
		rd_chk(7'h42, 13'h1001);
		rd_chk(7'h43, 13'h0000);
	endtask
	// reset again in mid-run; everything must read back cleared
	task automatic sc_mid_reset;
		@(posedge i_ref_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		sc_reset();
	endtask
	task automatic wrap_up;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		sc_reset();
		sc_groups();
		sc_channels();
		sc_mid_reset();
		wrap_up();
	end
endmodule
